// ==== mxb_access.sv ====
`timescale 1ns/1ps

module mxb_access
    import mxb_pkg::*;
#(
    parameter int ADDR_W = 24,
    parameter int DATA_W = 16
) (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic req_valid_in,
    input wire logic req_write_in,
    input wire logic [ADDR_W-1:0] req_addr_in,
    input wire logic [DATA_W-1:0] req_wdata_in,
    input wire logic simplex_mode_in,
    input wire logic [ADDR_LEN_W-1:0] address_phase_len_in,
    input wire logic [SETUP_LEN_W-1:0] data_setup_phase_len_in,
    input wire logic [STROBE_LEN_W-1:0] strobe_phase_len_in,
    input wire logic [HOLD_LEN_W-1:0] hold_phase_len_in,
    input wire logic [RECOV_LEN_W-1:0] recovery_phase_len_in,
    input wire logic [CS_DLY_W-1:0] cs_delay_len_in,
    input wire logic [DATA_W-1:0] ad_in,
    output logic req_ready_out,
    output logic [DATA_W-1:0] rd_data_out,
    output logic rd_valid_out,
    output logic address_latch_strobe_out,
    output logic [ADDR_W-1:0] expansion_address_out,
    output logic chip_select_n_out,
    output logic read_strobe_pin_n_out,
    output logic write_strobe_pin_n_out,
    output logic [DATA_W-1:0] ad_out,
    output logic ad_oe_out
);

    mxb_state_t state_q, state_d;
    logic accept;

    // access settings frozen for the whole access
    logic lat_write_q, lat_write_d;
    logic lat_simplex_q, lat_simplex_d;
    logic [ADDR_W-1:0] lat_addr_q, lat_addr_d;
    logic [DATA_W-1:0] lat_wdata_q, lat_wdata_d;
    logic [ADDR_LEN_W-1:0] lat_alen_q, lat_alen_d;
    logic [SETUP_LEN_W-1:0] lat_slen_q, lat_slen_d;
    logic [STROBE_LEN_W-1:0] lat_tlen_q, lat_tlen_d;
    logic [HOLD_LEN_W-1:0] lat_hlen_q, lat_hlen_d;
    logic [RECOV_LEN_W-1:0] lat_rlen_q, lat_rlen_d;
    logic [CS_DLY_W-1:0] lat_cs_q, lat_cs_d;

    // registered pin images
    logic ale_q, ale_d;
    logic cs_n_q, cs_n_d;
    logic rd_n_q, rd_n_d;
    logic wr_n_q, wr_n_d;
    logic oe_q, oe_d;
    logic [DATA_W-1:0] ad_q, ad_d;
    logic ready_q, ready_d;

    // read capture path
    logic [DATA_W-1:0] ad_sync1_q, ad_sync2_q;
    logic cap_p1_q, cap_p1_d;
    logic cap_p2_q, cap_p2_d;
    logic [DATA_W-1:0] rd_data_q, rd_data_d;
    logic rd_valid_q, rd_valid_d;

    mxb_timer_if #(.CNT_W(PHASE_CNT_W)) tmr ();

    mxb_phase_timer #(.CNT_W(PHASE_CNT_W)) u_timer (
        .mclk_in (mclk_in),
        .rst_n_in (rst_n_in),
        .tmr (tmr)
    );

    assign accept = req_valid_in && ready_q;

    always_comb begin
        lat_write_d = lat_write_q;
        lat_simplex_d = lat_simplex_q;
        lat_addr_d = lat_addr_q;
        lat_wdata_d = lat_wdata_q;
        lat_alen_d = lat_alen_q;
        lat_slen_d = lat_slen_q;
        lat_tlen_d = lat_tlen_q;
        lat_hlen_d = lat_hlen_q;
        lat_rlen_d = lat_rlen_q;
        lat_cs_d = lat_cs_q;
        if (accept) begin
            lat_write_d = req_write_in;
            lat_simplex_d = simplex_mode_in;
            lat_addr_d = req_addr_in;
            lat_wdata_d = req_wdata_in;
            lat_alen_d = address_phase_len_in;
            lat_slen_d = data_setup_phase_len_in;
            lat_tlen_d = strobe_phase_len_in;
            lat_hlen_d = hold_phase_len_in;
            lat_rlen_d = recovery_phase_len_in;
            lat_cs_d = cs_delay_len_in;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            lat_write_q <= 1'b0;
            lat_simplex_q <= 1'b0;
            lat_addr_q <= '0;
            lat_wdata_q <= '0;
            lat_alen_q <= '0;
            lat_slen_q <= '0;
            lat_tlen_q <= '0;
            lat_hlen_q <= '0;
            lat_rlen_q <= '0;
            lat_cs_q <= '0;
        end else begin
            lat_write_q <= lat_write_d;
            lat_simplex_q <= lat_simplex_d;
            lat_addr_q <= lat_addr_d;
            lat_wdata_q <= lat_wdata_d;
            lat_alen_q <= lat_alen_d;
            lat_slen_q <= lat_slen_d;
            lat_tlen_q <= lat_tlen_d;
            lat_hlen_q <= lat_hlen_d;
            lat_rlen_q <= lat_rlen_d;
            lat_cs_q <= lat_cs_d;
        end
    end

    always_comb begin
        state_d = state_q;
        tmr.load = 1'b0;
        tmr.load_val = '0;
        case (state_q)
            S_IDLE: begin
                if (accept) begin
                    tmr.load = 1'b1;
                    tmr.load_val = PHASE_CNT_W'(address_phase_len_in);
                    state_d = simplex_mode_in ? S_ASETUP : S_ALE;
                end
            end
            S_ALE: begin
                if (tmr.done) begin
                    tmr.load = 1'b1;
                    tmr.load_val = PHASE_CNT_W'(ADDR_HOLD_CYCLES - LEN_BIAS);
                    state_d = S_AHOLD;
                end
            end
            S_AHOLD: begin
                tmr.load = 1'b1;
                if (lat_cs_q == '0) begin
                    tmr.load_val = PHASE_CNT_W'(lat_slen_q);
                    state_d = S_SETUP;
                end else begin
                    tmr.load_val = PHASE_CNT_W'(lat_cs_q - CS_DLY_W'(LEN_BIAS));
                    state_d = S_CSWAIT;
                end
            end
            S_CSWAIT, S_ASETUP: begin
                if (tmr.done) begin
                    tmr.load = 1'b1;
                    tmr.load_val = PHASE_CNT_W'(lat_slen_q);
                    state_d = S_SETUP;
                end
            end
            S_SETUP: begin
                if (tmr.done) begin
                    tmr.load = 1'b1;
                    tmr.load_val = PHASE_CNT_W'(lat_tlen_q);
                    state_d = S_STROBE;
                end
            end
            S_STROBE: begin
                if (tmr.done) begin
                    tmr.load = 1'b1;
                    tmr.load_val = PHASE_CNT_W'(lat_hlen_q);
                    state_d = S_HOLD;
                end
            end
            S_HOLD: begin
                if (tmr.done) begin
                    tmr.load = 1'b1;
                    tmr.load_val = PHASE_CNT_W'(lat_rlen_q);
                    state_d = S_RECOV;
                end
            end
            S_RECOV: begin
                if (tmr.done) begin
                    state_d = S_IDLE;
                end
            end
            default: begin
                state_d = S_IDLE;
            end
        endcase
    end

    always_comb begin
        ready_d = (state_d == S_IDLE);
        ale_d = (state_d == S_ALE);
        cs_n_d = (state_d == S_SETUP || state_d == S_STROBE || state_d == S_HOLD) ? PIN_ACTIVE : PIN_INACTIVE;
        rd_n_d = (state_d == S_STROBE && !lat_write_d) ? PIN_ACTIVE : PIN_INACTIVE;
        wr_n_d = (state_d == S_STROBE && lat_write_d) ? PIN_ACTIVE : PIN_INACTIVE;
        oe_d = 1'b0;
        ad_d = ad_q;
        if (state_d == S_ALE || state_d == S_AHOLD) begin
            oe_d = 1'b1;
            ad_d = lat_addr_d[DATA_W-1:0];
        end else if (lat_write_d && (state_d == S_SETUP || state_d == S_STROBE || state_d == S_HOLD)) begin
            oe_d = 1'b1;
            ad_d = lat_wdata_d;
        end
    end

    always_comb begin
        cap_p1_d = (state_q == S_STROBE) && (state_d != S_STROBE) && !lat_write_q;
        cap_p2_d = cap_p1_q;
        rd_valid_d = cap_p2_q;
        rd_data_d = cap_p2_q ? ad_sync2_q : rd_data_q;
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q <= S_IDLE;
            ready_q <= 1'b0;
            ale_q <= 1'b0;
            cs_n_q <= PIN_INACTIVE;
            rd_n_q <= PIN_INACTIVE;
            wr_n_q <= PIN_INACTIVE;
            oe_q <= 1'b0;
            ad_q <= '0;
            ad_sync1_q <= '0;
            ad_sync2_q <= '0;
            cap_p1_q <= 1'b0;
            cap_p2_q <= 1'b0;
            rd_valid_q <= 1'b0;
            rd_data_q <= '0;
        end else begin
            state_q <= state_d;
            ready_q <= ready_d;
            ale_q <= ale_d;
            cs_n_q <= cs_n_d;
            rd_n_q <= rd_n_d;
            wr_n_q <= wr_n_d;
            oe_q <= oe_d;
            ad_q <= ad_d;
            ad_sync1_q <= ad_in;
            ad_sync2_q <= ad_sync1_q;
            cap_p1_q <= cap_p1_d;
            cap_p2_q <= cap_p2_d;
            rd_valid_q <= rd_valid_d;
            rd_data_q <= rd_data_d;
        end
    end

    assign req_ready_out = ready_q;
    assign rd_data_out = rd_data_q;
    assign rd_valid_out = rd_valid_q;
    assign address_latch_strobe_out = ale_q;
    assign expansion_address_out = lat_addr_q;
    assign chip_select_n_out = cs_n_q;
    assign read_strobe_pin_n_out = rd_n_q;
    assign write_strobe_pin_n_out = wr_n_q;
    assign ad_out = ad_q;
    assign ad_oe_out = oe_q;
    // dwell counter for phase checks
    logic leaving;
    logic [DWELL_W-1:0] dwell_q;
    assign leaving = (state_d != state_q);
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            dwell_q <= DWELL_W'(1);
        end else begin
            dwell_q <= leaving ? DWELL_W'(1) : dwell_q + DWELL_W'(1);
        end
    end

    AST_ALE_WIDTH: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (state_q == S_ALE && leaving) |-> dwell_q == DWELL_W'(lat_alen_q) + DWELL_W'(LEN_BIAS)
    ) else $error("latch strobe width differs from address phase length");
    AST_ADDR_HOLD: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        $fell(address_latch_strobe_out) |-> ad_oe_out && ad_out == lat_addr_q[DATA_W-1:0]
            ##1 (!ad_oe_out || (lat_write_q && ad_out == lat_wdata_q))
    ) else $error("address hold after latch strobe not one cycle");
    AST_CS_AFTER_ALE: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        $fell(address_latch_strobe_out) |-> chip_select_n_out ##[1:4] !chip_select_n_out
    ) else $error("chip select not within four cycles of latch fall");
    AST_SETUP_LEN: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (state_q == S_SETUP && leaving) |-> dwell_q == DWELL_W'(lat_slen_q) + DWELL_W'(LEN_BIAS)
    ) else $error("data setup length wrong");
    AST_STROBE_LEN: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (state_q == S_STROBE && leaving) |-> dwell_q == DWELL_W'(lat_tlen_q) + DWELL_W'(LEN_BIAS)
    ) else $error("strobe length wrong");
    AST_WDATA_ON_STROBE: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        !write_strobe_pin_n_out |-> ad_oe_out && ad_out == lat_wdata_q && !chip_select_n_out
    ) else $error("write data not driven under write strobe");
    AST_HOLD_LEN: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (state_q == S_HOLD && leaving) |-> dwell_q == DWELL_W'(lat_hlen_q) + DWELL_W'(LEN_BIAS)
    ) else $error("hold length wrong");
    AST_RECOV_LEN: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (state_q == S_RECOV && leaving) |-> dwell_q == DWELL_W'(lat_rlen_q) + DWELL_W'(LEN_BIAS)
    ) else $error("recovery gap length wrong");
    AST_RD_CAPTURE: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        $rose(read_strobe_pin_n_out) |-> ##2 rd_valid_out && rd_data_out == $past(ad_in, 3)
    ) else $error("read data not captured at strobe rise");
    AST_SIMPLEX_NO_ALE: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        lat_simplex_q |-> !address_latch_strobe_out
    ) else $error("latch strobe active in simplex access");
    AST_ORDER: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (state_q == S_STROBE && leaving) |=> state_q == S_HOLD
    ) else $error("phase order broken after strobe");
endmodule // mxb_access

// ==== mxb_access_test.sv ====
`timescale 1ns/1ps

module mxb_access_test
    import mxb_pkg::*;
;
    logic mclk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic simplex = 1'b0;
    logic slow = 1'b0;
    logic [23:0] req_addr = 24'h00_0000;
    logic [15:0] req_wdata = 16'h0000;
    logic [1:0] al_r = 2'h0, sl_r = 2'h0, hl_r = 2'h0, cl_r = 2'h0;
    logic [3:0] tl_r = 4'h0, rl_r = 4'h0;
    logic ready, rd_valid, latch, sel_n, rstb_n, wstb_n, oe;
    logic [15:0] rd_data, ad_o, pm_d;
    logic [23:0] xaddr;
    wire [15:0] bus = oe ? ad_o : pm_d;
    int checks = 0;
    int n_fail = 0;
    int p, cur = 0, cnt = 0, rd_cnt = 0;
    int len [7];
    logic seen_cs = 1'b0, seen_st = 1'b0, w_e = 1'b0;
    logic [23:0] a_e = 24'h00_0000;
    logic [15:0] d_e = 16'h0000, rd_got = 16'h0000;

    always #2.5 mclk_in = ~mclk_in;

    mxb_access dut (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .req_valid_in(req_valid),
        .req_write_in(req_write),
        .req_addr_in(req_addr),
        .req_wdata_in(req_wdata),
        .simplex_mode_in(simplex),
        .address_phase_len_in(al_r),
        .data_setup_phase_len_in(sl_r),
        .strobe_phase_len_in(tl_r),
        .hold_phase_len_in(hl_r),
        .recovery_phase_len_in(rl_r),
        .cs_delay_len_in(cl_r),
        .ad_in(bus),
        .req_ready_out(ready),
        .rd_data_out(rd_data),
        .rd_valid_out(rd_valid),
        .address_latch_strobe_out(latch),
        .expansion_address_out(xaddr),
        .chip_select_n_out(sel_n),
        .read_strobe_pin_n_out(rstb_n),
        .write_strobe_pin_n_out(wstb_n),
        .ad_out(ad_o),
        .ad_oe_out(oe)
    );

    mxb_periph_model pm (
        .clk_in(mclk_in),
        .latch_in(latch),
        .sel_n_in(sel_n),
        .rstb_n_in(rstb_n),
        .wstb_n_in(wstb_n),
        .slow_in(slow),
        .addr_in(xaddr),
        .bus_in(bus),
        .drv_out(pm_d)
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic conclude();
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // phase tracker: 1 latch, 2 to select, 3 setup, 4 strobe, 5 hold, 6 recovery
    always @(negedge mclk_in) begin
        if (rst_n_in === 1'b1) begin
            p = ready ? 0 : latch ? 1 : sel_n ? (seen_cs ? 6 : 2) : (rstb_n && wstb_n) ? (seen_st ? 5 : 3) : 4;
            if (p == 2 && cur == 1) chk({oe, ad_o}, {1'b1, a_e[15:0]});
            if (w_e && p >= 3 && p <= 5) chk({oe, ad_o}, {1'b1, d_e});
            if (!w_e && p == 4) chk(oe, 1'b0);
            if (p == 4) chk({rstb_n, wstb_n}, w_e ? 2'h2 : 2'h1);
            if (p == 4) chk(xaddr, a_e);
            if (rd_valid === 1'b1) begin
                rd_got = rd_data;
                rd_cnt++;
            end
            if (p == cur) begin
                cnt++;
            end else begin
                len[cur] = cnt;
                cur = p;
                cnt = 1;
            end
            if (p >= 3 && p <= 5) seen_cs = 1'b1;
            if (p == 4) seen_st = 1'b1;
            if (p < 2) begin
                seen_cs = 1'b0;
                seen_st = 1'b0;
            end
        end
    end

    task automatic acc(input logic w, input logic sx, input logic [23:0] a, input logic [15:0] d,
                       input logic [1:0] al, input logic [1:0] sl, input logic [3:0] tl,
                       input logic [1:0] hl, input logic [3:0] rl, input logic [1:0] cl);
        int i;
        @(posedge mclk_in);
        {req_write, simplex, req_addr, req_wdata} <= {w, sx, a, d};
        {al_r, sl_r, tl_r, hl_r, rl_r, cl_r} <= {al, sl, tl, hl, rl, cl};
        req_valid <= 1'b1;
        {w_e, a_e, d_e} = {w, a, d};
        len = '{default: 0};
        rd_cnt = 0;
        i = 0;
        do begin @(negedge mclk_in); i++; end while (ready !== 1'b1 && i < 300);
        @(posedge mclk_in);
        {req_write, simplex, req_addr, req_wdata} <= ~{w, sx, a, d};
        {al_r, sl_r, tl_r, hl_r, rl_r, cl_r} <= ~{al, sl, tl, hl, rl, cl};
        req_valid <= 1'b0;
        do begin @(negedge mclk_in); i++; end while (ready !== 1'b1 && i < 300);
        if (i >= 300) begin
            n_fail++;
            conclude();
        end
        @(posedge mclk_in);
        chk(len[1], sx ? 0 : al + 1);
        chk(len[2], (sx ? al : cl) + 1);
        chk(len[3], sl + 1);
        chk(len[4], tl + 1);
        chk(len[5], hl + 1);
        chk(len[6], rl + 1);
        if (!w) begin
            chk(rd_cnt, 1);
            chk(rd_got, d);
        end
    endtask

    initial begin
        repeat (5) @(posedge mclk_in);
        @(negedge mclk_in);
        chk({ready, latch, sel_n, rstb_n, wstb_n, oe, rd_valid}, 7'h1c);
        @(posedge mclk_in);
        rst_n_in <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            acc(1'b1, 1'b0, 24'(k), 16'ha5c3 ^ 16'(k), 2'(k), 2'(3 - k), 4'(5 * k), 2'(k), 4'(15 - 5 * k), 2'(3 - k));
        end
        // even reads answer promptly, odd ones a cycle late
        for (int k = 0; k < 4; k++) begin
            slow <= k[0];
            acc(1'b0, 1'b0, 24'(k), 16'ha5c3 ^ 16'(k), 2'(3 - k), 2'(k), 4'(2 + k), 2'(3 - k), 4'(k), 2'(k));
        end
        slow <= 1'b1;
        acc(1'b1, 1'b1, 24'hab_cd09, 16'h0ff0, 2'h2, 2'h1, 4'h4, 2'h0, 4'h1, 2'h0);
        acc(1'b0, 1'b1, 24'hab_cd09, 16'h0ff0, 2'h3, 2'h0, 4'h3, 2'h3, 4'h0, 2'h0);
        conclude();
    end
endmodule // mxb_access_test

// ==== mxb_periph_model.sv ====
`timescale 1ns/1ps

// far-side peripheral: latches the address, stores writes, answers reads
module mxb_periph_model (
    input wire logic clk_in,
    input wire logic latch_in,
    input wire logic sel_n_in,
    input wire logic rstb_n_in,
    input wire logic wstb_n_in,
    input wire logic slow_in,
    input wire logic [23:0] addr_in,
    input wire logic [15:0] bus_in,
    output logic [15:0] drv_out
);
    logic [15:0] mem [16];
    logic [3:0] a_q = 4'h0;
    logic mux_q = 1'b0;
    logic wr_q = 1'b1;
    logic sel_q = 1'b1;
    int n = 0;
    logic [15:0] dq = 16'h0000;
    wire [3:0] idx = mux_q ? a_q : addr_in[3:0];

    // data dropped right after the strobe rises: zero hold
    assign drv_out = rstb_n_in ? ~dq : dq;

    always @(posedge clk_in) begin
        wr_q <= wstb_n_in;
        sel_q <= sel_n_in;
        if (latch_in) begin
            a_q <= bus_in[3:0];
            mux_q <= 1'b1;
        end else if (!sel_q && sel_n_in) begin
            mux_q <= 1'b0;
        end
        if (!wr_q && wstb_n_in) begin
            mem[idx] <= bus_in;
        end
        if (!rstb_n_in && !sel_n_in) begin
            n <= n + 1;
            dq <= (n >= int'(slow_in)) ? mem[idx] : ~dq;
        end else begin
            // released bus toggles every cycle, so it never keeps the last value
            n <= 0;
            dq <= ~dq;
        end
    end
endmodule // mxb_periph_model

// ==== mxb_phase_timer.sv ====
`timescale 1ns/1ps

// counts down a loaded phase length; done in the phase's last cycle
module mxb_phase_timer #(
    parameter int CNT_W = 4
) (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    mxb_timer_if.timer tmr
);
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;

    always_comb begin
        cnt_d = cnt_q;
        if (tmr.load) begin
            cnt_d = tmr.load_val;
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - CNT_W'(1);
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign tmr.done = (cnt_q == '0);

endmodule // mxb_phase_timer

// ==== mxb_pkg.sv ====
package mxb_pkg;

    // widths of the programmed phase fields
    localparam int ADDR_LEN_W = 2;
    localparam int SETUP_LEN_W = 2;
    localparam int STROBE_LEN_W = 4;
    localparam int HOLD_LEN_W = 2;
    localparam int RECOV_LEN_W = 4;
    localparam int CS_DLY_W = 2;

    // shared phase counter and dwell monitor widths
    localparam int PHASE_CNT_W = 4;
    localparam int DWELL_W = 5;

    // a programmed field of n means n + 1 clock periods
    localparam int LEN_BIAS = 1;

    // address stays on the bus this many cycles after the latch strobe falls
    localparam int ADDR_HOLD_CYCLES = 1;

    // read data passes two sync stages before capture
    localparam int RD_CAPTURE_DELAY = 2;

    // pin levels
    localparam logic PIN_INACTIVE = 1'b1;
    localparam logic PIN_ACTIVE = 1'b0;

    typedef enum logic [3:0] {
        S_IDLE,
        S_ALE,
        S_AHOLD,
        S_CSWAIT,
        S_ASETUP,
        S_SETUP,
        S_STROBE,
        S_HOLD,
        S_RECOV
    } mxb_state_t;

endpackage

// ==== mxb_timer_if.sv ====
`timescale 1ns/1ps

interface mxb_timer_if #(
    parameter int CNT_W = 4
);
    logic load;
    logic [CNT_W-1:0] load_val;
    logic done;

    modport owner (output load, output load_val, input done);
    modport timer (input load, input load_val, output done);
endinterface
